// ==== pkg/tcc_pkg.sv ====
// Constants for the time and calendar counter block
package tcc_pkg;
  localparam logic [4:0] ADDR_HUNDREDTHS = 5'h10;
  localparam logic [4:0] ADDR_SECONDS    = 5'h00;
  localparam logic [4:0] ADDR_MINUTES    = 5'h01;
  localparam logic [4:0] ADDR_HOURS      = 5'h02;
  localparam logic [4:0] ADDR_WEEKDAY    = 5'h03;
  localparam logic [4:0] ADDR_DAY        = 5'h04;
  localparam logic [4:0] ADDR_MONTH      = 5'h05;
  localparam logic [4:0] ADDR_YEAR       = 5'h06;
  localparam logic [4:0] ADDR_CONTROL    = 5'h0F;
  localparam logic [4:0] ADDR_SECONDS_M  = 5'h11;
  localparam logic [4:0] ADDR_MINUTES_M  = 5'h12;
  localparam logic [4:0] ADDR_HOURS_M    = 5'h13;
  localparam logic [4:0] ADDR_WEEKDAY_M  = 5'h14;
  localparam logic [4:0] ADDR_DAY_M      = 5'h15;
  localparam logic [4:0] ADDR_MONTH_M    = 5'h16;
  localparam logic [4:0] ADDR_YEAR_M     = 5'h17;
  localparam logic [4:0] ADDR_CONTROL_M  = 5'h1F;
  localparam int         CTRL_RESET_BIT  = 0;
  localparam logic [7:0] MASK_SEC        = 8'h7F;
  localparam logic [7:0] MASK_HOUR       = 8'h3F;
  localparam logic [7:0] MASK_WDAY       = 8'h7F;
  localparam logic [7:0] MASK_MONTH      = 8'h1F;
  localparam logic [7:0] MASK_YEAR       = 8'hFF;
  localparam logic [7:0] MAX_SEC         = 8'h59;
  localparam logic [7:0] MAX_HOUR        = 8'h23;
  localparam logic [7:0] MAX_HUND        = 8'h99;
  localparam logic [7:0] MAX_MONTH       = 8'h12;
  localparam logic [7:0] FIRST_DAY       = 8'h01;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_ONE         = 8'h01;
  localparam logic [6:0] WDAY_FIRST      = 7'h01;
  localparam int         CLK_HZ          = 25000000;
  localparam int         HUND_HZ         = 100;
  localparam int         HUND_CYCLES     = CLK_HZ / HUND_HZ;
endpackage : tcc_pkg

// ==== pkg/tcc_reg_if.sv ====
// Register access bundle between port decoder and counters
`timescale 1ns/10ps
`default_nettype none
interface tcc_reg_if;
  logic       wr_en;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dec (output wr_en, output addr, output wdata, input rdata);
  modport core (input wr_en, input addr, input wdata, output rdata);
endinterface : tcc_reg_if
`default_nettype wire

// ==== design/tcc_prescale.sv ====
// Hundredths-of-a-second strobe generator
`timescale 1ns/10ps
`default_nettype none
module tcc_prescale #(
  parameter int DIV = tcc_pkg::HUND_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic halt_i,
  output logic      tick_o
);
  // Elaboration check: the strobe needs a divider of at least two
  if (DIV < 2) begin : g_div_check
    $error("DIV too small");
  end
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_next;
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (halt_i) begin
      cnt_next = '0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= tick_next;
    end
  end
endmodule : tcc_prescale
`default_nettype wire

// ==== design/tcc_counters.sv ====
// Time and calendar counters with mirrored register port
// Behaviour
// RQ1: Seconds are BCD 00-59 in bits 6:0; bit 7 reads zero.
// RQ2: Any write to seconds, either address, clears hundredths to 00.
// RQ3: Counter-reset bit set stops the tick; seconds hold.
// RQ4: Minutes are BCD 00-59 in bits 6:0; bit 7 reads zero.
// RQ5: Hours are 24-hour BCD 00-23 in bits 5:0; bits 7:6 zero.
// RQ6: Each counter except hundredths is one register seen at both address banks.
// RQ7: Weekday is one-hot in bits 6:0, day n at bit n-1.
// RQ8: Host writes weekday with exactly one bit set.
// RQ9: Day of month is BCD 01-31 in bits 5:0; bits 7:6 zero.
// RQ10: Host loads a valid day 01-31 after power-on.
// RQ11: February has 29 days in years divisible by four.
// RQ12: Hundredths counter is read-only BCD 00-99; carry ticks seconds.
// RQ13: Month is BCD 01-12 in bits 4:0, advanced by day rollover.
// RQ14: Year is BCD 00-99, incremented when month wraps 12 to 01.
// RQ15: Seconds, minutes, hours, day and weekday cascade on wrap.
// RQ16: Weekday bit rotates toward bit 6, then back to bit 0.
`timescale 1ns/10ps
`default_nettype none
module tcc_counters #(
  parameter int HUND_DIV = tcc_pkg::HUND_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_en_i,
  input  wire logic [4:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] seconds_o,
  output logic      [7:0] day_o,
  output logic            halted_o
);
  // ==========================================================
  // Types and helpers
  typedef enum {TCC_RUN, TCC_HALT} tcc_state_t;

  tcc_reg_if rif ();
  assign rif.wr_en = wr_en_i;
  assign rif.addr  = addr_i;
  assign rif.wdata = wdata_i;

  // BCD increment; returns first value and wrap flag past max
  function automatic logic [8:0] tcc_bcd_inc(input logic [7:0] v,
                                             input logic [7:0] mx,
                                             input logic [7:0] lo);
    logic [7:0] r;
    r = v;
    if (v >= mx) begin
      return {1'b1, lo};
    end
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {1'b0, r};
  endfunction : tcc_bcd_inc

  // Whether the address is the given register in either bank
  function automatic logic tcc_hit(input logic [4:0] a,
                                   input logic [4:0] lo,
                                   input logic [4:0] hi);
    return (a == lo) || (a == hi);
  endfunction : tcc_hit

  // ==========================================================
  // Counter state
  logic [7:0] hund_reg, hund_next;
  logic [7:0] sec_reg, sec_next;
  logic [7:0] min_reg, min_next;
  logic [7:0] hour_reg, hour_next;
  logic [6:0] wday_reg, wday_next;
  logic [7:0] day_reg, day_next;
  logic [7:0] mon_reg, mon_next;
  logic [7:0] year_reg, year_next;
  logic       ctrl_rst_reg, ctrl_rst_next;
  logic [7:0] rdata_reg, rdata_next;
  tcc_state_t state_reg, state_next;
  logic       hund_tick;
  logic [7:0] last_day;
  logic       leap;
  logic [8:0] h_i, s_i, m_i, hr_i, d_i, mo_i, y_i;
  logic       w_sec;

  // RQ3 stopped tick
  tcc_prescale #(.DIV(HUND_DIV)) u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .halt_i  (ctrl_rst_reg),
    .tick_o  (hund_tick)
  );

  // ==========================================================
  // Next-value logic
  always_comb begin
    // RQ11 leap year check
    leap = (year_reg[4] == 1'b0 && (year_reg[3:0] == 4'h0 ||
            year_reg[3:0] == 4'h4 || year_reg[3:0] == 4'h8)) ||
           (year_reg[4] == 1'b1 && (year_reg[3:0] == 4'h2 ||
            year_reg[3:0] == 4'h6));
    case (mon_reg)
      8'h02:   last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
    h_i  = tcc_bcd_inc(hund_reg, tcc_pkg::MAX_HUND, tcc_pkg::RST_ZERO);
    s_i  = tcc_bcd_inc(sec_reg, tcc_pkg::MAX_SEC, tcc_pkg::RST_ZERO);
    m_i  = tcc_bcd_inc(min_reg, tcc_pkg::MAX_SEC, tcc_pkg::RST_ZERO);
    hr_i = tcc_bcd_inc(hour_reg, tcc_pkg::MAX_HOUR, tcc_pkg::RST_ZERO);
    d_i  = tcc_bcd_inc(day_reg, last_day, tcc_pkg::FIRST_DAY);
    mo_i = tcc_bcd_inc(mon_reg, tcc_pkg::MAX_MONTH, tcc_pkg::FIRST_DAY);
    y_i  = tcc_bcd_inc(year_reg, tcc_pkg::MAX_HUND, tcc_pkg::RST_ZERO);
    hund_next = hund_reg;
    sec_next  = sec_reg;
    min_next  = min_reg;
    hour_next = hour_reg;
    wday_next = wday_reg;
    day_next  = day_reg;
    mon_next  = mon_reg;
    year_next = year_reg;
    ctrl_rst_next = ctrl_rst_reg;
    // RQ12 hundredths carry
    if (hund_tick && state_reg == TCC_RUN) begin
      hund_next = h_i[7:0];
      if (h_i[8]) begin
        sec_next = s_i[7:0];
        // RQ15 cascade on wrap
        if (s_i[8]) begin
          min_next = m_i[7:0];
          if (m_i[8]) begin
            hour_next = hr_i[7:0];
            if (hr_i[8]) begin
              // RQ16 weekday rotation
              wday_next = {wday_reg[5:0], wday_reg[6]};
              day_next  = d_i[7:0];
              // RQ13 month advance
              if (d_i[8]) begin
                mon_next = mo_i[7:0];
                // RQ14 year advance
                if (mo_i[8]) begin
                  year_next = y_i[7:0];
                end
              end
            end
          end
        end
      end
    end
    // RQ6 one register per counter at both banks
    w_sec = rif.wr_en &&
            tcc_hit(rif.addr, tcc_pkg::ADDR_SECONDS, tcc_pkg::ADDR_SECONDS_M);
    if (rif.wr_en) begin
      // RQ1 seconds width
      if (w_sec) begin
        sec_next  = rif.wdata & tcc_pkg::MASK_SEC;
        // RQ2 hundredths cleared
        hund_next = tcc_pkg::RST_ZERO;
      end
      // RQ4 minutes width
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_MINUTES, tcc_pkg::ADDR_MINUTES_M))
        min_next = rif.wdata & tcc_pkg::MASK_SEC;
      // RQ5 hours width
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_HOURS, tcc_pkg::ADDR_HOURS_M))
        hour_next = rif.wdata & tcc_pkg::MASK_HOUR;
      // RQ7 weekday one-hot
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_WEEKDAY, tcc_pkg::ADDR_WEEKDAY_M))
        wday_next = rif.wdata[6:0];
      // RQ9 day width
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_DAY, tcc_pkg::ADDR_DAY_M))
        day_next = rif.wdata & tcc_pkg::MASK_HOUR;
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_MONTH, tcc_pkg::ADDR_MONTH_M))
        mon_next = rif.wdata & tcc_pkg::MASK_MONTH;
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_YEAR, tcc_pkg::ADDR_YEAR_M))
        year_next = rif.wdata & tcc_pkg::MASK_YEAR;
      if (tcc_hit(rif.addr, tcc_pkg::ADDR_CONTROL, tcc_pkg::ADDR_CONTROL_M))
        ctrl_rst_next = rif.wdata[tcc_pkg::CTRL_RESET_BIT];
    end
    state_next = ctrl_rst_next ? TCC_HALT : TCC_RUN;
    // Read mux, registered
    case (rif.addr)
      tcc_pkg::ADDR_HUNDREDTHS: rdata_next = hund_next;
      tcc_pkg::ADDR_SECONDS, tcc_pkg::ADDR_SECONDS_M:
        rdata_next = sec_next;
      tcc_pkg::ADDR_MINUTES, tcc_pkg::ADDR_MINUTES_M:
        rdata_next = min_next;
      tcc_pkg::ADDR_HOURS, tcc_pkg::ADDR_HOURS_M:
        rdata_next = hour_next;
      tcc_pkg::ADDR_WEEKDAY, tcc_pkg::ADDR_WEEKDAY_M:
        rdata_next = {1'b0, wday_next};
      tcc_pkg::ADDR_DAY, tcc_pkg::ADDR_DAY_M:
        rdata_next = day_next;
      tcc_pkg::ADDR_MONTH, tcc_pkg::ADDR_MONTH_M:
        rdata_next = mon_next;
      tcc_pkg::ADDR_YEAR, tcc_pkg::ADDR_YEAR_M:
        rdata_next = year_next;
      tcc_pkg::ADDR_CONTROL, tcc_pkg::ADDR_CONTROL_M:
        rdata_next = {7'h00, ctrl_rst_next};
      default: rdata_next = tcc_pkg::RST_ZERO;
    endcase
  end
  assign rif.rdata = rdata_reg;

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hund_reg     <= tcc_pkg::RST_ZERO;
      sec_reg      <= tcc_pkg::RST_ZERO;
      min_reg      <= tcc_pkg::RST_ZERO;
      hour_reg     <= tcc_pkg::RST_ZERO;
      wday_reg     <= tcc_pkg::WDAY_FIRST;
      day_reg      <= tcc_pkg::RST_ONE;
      mon_reg      <= tcc_pkg::RST_ONE;
      year_reg     <= tcc_pkg::RST_ZERO;
      ctrl_rst_reg <= 1'b0;
      rdata_reg    <= tcc_pkg::RST_ZERO;
      state_reg    <= TCC_RUN;
    end else begin
      hund_reg     <= hund_next;
      sec_reg      <= sec_next;
      min_reg      <= min_next;
      hour_reg     <= hour_next;
      wday_reg     <= wday_next;
      day_reg      <= day_next;
      mon_reg      <= mon_next;
      year_reg     <= year_next;
      ctrl_rst_reg <= ctrl_rst_next;
      rdata_reg    <= rdata_next;
      state_reg    <= state_next;
    end
  end
  assign rdata_o   = rif.rdata;
  assign seconds_o = sec_reg;
  assign day_o     = day_reg;
  assign halted_o  = ctrl_rst_reg;

  // ==========================================================
  // Checks
  // RQ1 top bit zero
  AST_SEC_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    seconds_o[7] == 1'b0) else $error("seconds bit 7 set");  // RQ1
  // RQ2 write clears hundredths
  AST_SEC_WR_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    w_sec |=> hund_reg == 8'h00) else $error("hundredths not cleared");  // RQ2
  // RQ3 halted seconds hold
  AST_HALT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_rst_reg && !rif.wr_en |=> $stable(sec_reg))
    else $error("seconds moved while halted");  // RQ3
  // RQ4 minutes range
  AST_MIN_TOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    min_reg[7] == 1'b0) else $error("minutes bit 7 set");  // RQ4
  // RQ5 hours range
  AST_HOUR_TOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hour_reg[7:6] == 2'b00) else $error("hours top bits set");  // RQ5
  // RQ6 mirror write visible
  AST_MIRROR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rif.wr_en && rif.addr == tcc_pkg::ADDR_MINUTES_M && !hund_tick
    |=> min_reg == $past(rif.wdata & 8'h7F))
    else $error("mirror write lost");  // RQ6
  // RQ9 day top bits
  AST_DAY_TOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    day_reg[7:6] == 2'b00) else $error("day top bits set");  // RQ9
  // RQ16 weekday rotation on hour wrap
  AST_WDAY_ROT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hund_tick && state_reg == TCC_RUN && h_i[8] && s_i[8] && m_i[8] &&
    hr_i[8] && !rif.wr_en
    |=> wday_reg == {$past(wday_reg[5:0]), $past(wday_reg[6])})
    else $error("weekday did not rotate");  // RQ16
endmodule : tcc_counters
`default_nettype wire

// ==== test/tcc_host_model.sv ====
// Host side model: register writes and reads over the block port
`timescale 1ns/10ps
`default_nettype none
module tcc_host_model (
  input  wire logic       clk_i,
  output logic            wr_en_o,
  output logic      [4:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    wr_en_o = 1'b0;
    addr_o  = 5'h00;
    wdata_o = 8'h00;
  end

  // ==========================================================
  // Access tasks, driven on the falling edge
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    // Released data no longer shows the last value
    wdata_o = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_reg
endmodule : tcc_host_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench for the time and calendar counters
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk_i;
  logic       rst_n_i;
  logic       wr_en;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] seconds;
  logic [7:0] day;
  logic       halted;
  int         n_errors;
  int         n_tests;
  logic [7:0] rd;
  logic [25:0] tbl [9];

  tcc_counters #(.HUND_DIV(4)) dut_u (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_en),
    .addr_i    (addr),
    .wdata_i   (wdata),
    .rdata_o   (rdata),
    .seconds_o (seconds),
    .day_o     (day),
    .halted_o  (halted)
  );

  tcc_host_model host_u (
    .clk_i   (clk_i),
    .wr_en_o (wr_en),
    .addr_o  (addr),
    .wdata_o (wdata),
    .rdata_i (rdata)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================
  // Comparison and verdict
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic rd_chk(input string nm, input logic [4:0] a,
                        input logic [7:0] exp);
    host_u.read_reg(a, rd);
    check(nm, rd, exp);
  endtask : rd_chk

  // ==========================================================
  // Load a date one second before midnight, run, then halt
  task automatic rollover(input logic [7:0] yr, mo, dy, wd,
                          input logic [7:0] e_dy, e_mo, e_yr, e_wd);
    int i;
    host_u.write_reg(5'h06, yr);
    host_u.write_reg(5'h05, mo);
    host_u.write_reg(5'h04, dy);
    host_u.write_reg(5'h03, wd);
    host_u.write_reg(5'h02, 8'h23);
    host_u.write_reg(5'h01, 8'h59);
    host_u.write_reg(5'h00, 8'h59);
    host_u.write_reg(5'h0F, 8'h00);
    for (i = 0; i < 1000 && seconds !== 8'h00; i++) begin
      @(negedge clk_i);
    end
    if (i == 1000) begin
      n_errors++;
      complete_run();
    end
    host_u.write_reg(5'h1F, 8'h01);
    check("day_o", day, e_dy);
    rd_chk("minutes", 5'h12, 8'h00);
    rd_chk("hours", 5'h02, 8'h00);
    rd_chk("day", 5'h15, e_dy);
    rd_chk("month", 5'h16, e_mo);
    rd_chk("year", 5'h17, e_yr);
    rd_chk("weekday", 5'h14, e_wd);
  endtask : rollover

  initial begin
    n_errors = 0;
    n_tests  = 0;
    tbl = '{{5'h11, 8'hC5, 5'h00, 8'h45}, {5'h01, 8'hD9, 5'h12, 8'h59},
            {5'h13, 8'hE3, 5'h02, 8'h23}, {5'h03, 8'h88, 5'h14, 8'h08},
            {5'h15, 8'hF1, 5'h04, 8'h31}, {5'h10, 8'h55, 5'h10, 8'h00},
            {5'h08, 8'hAA, 5'h08, 8'h00}, {5'h16, 8'hE9, 5'h05, 8'h09},
            {5'h06, 8'h37, 5'h17, 8'h37}};
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd_chk("sec_rst", 5'h00, 8'h00);
    rd_chk("wday_rst", 5'h03, 8'h01);
    check("halted_rst", {7'h00, halted}, 8'h00);
    // Let hundredths run, then freeze and clear them by a seconds write
    repeat (60) @(negedge clk_i);
    host_u.write_reg(5'h0F, 8'h01);
    host_u.read_reg(5'h10, rd);
    check("hund_run", {7'h00, rd !== 8'h00}, 8'h01);
    host_u.write_reg(5'h11, 8'h30);
    rd_chk("hund_clr", 5'h10, 8'h00);
    repeat (1000) @(negedge clk_i);
    check("sec_hold", seconds, 8'h30);
    check("halted", {7'h00, halted}, 8'h01);
    // Masked fields, mirrors, read-only and unmapped places
    foreach (tbl[k]) begin
      host_u.write_reg(tbl[k][25:21], tbl[k][20:13]);
      rd_chk("table", tbl[k][12:8], tbl[k][7:0]);
    end
    // Leap and non-leap February, year wrap, weekday wrap
    rollover(8'h24, 8'h02, 8'h28, 8'h40, 8'h29, 8'h02, 8'h24, 8'h01);
    rollover(8'h24, 8'h02, 8'h29, 8'h01, 8'h01, 8'h03, 8'h24, 8'h02);
    rollover(8'h23, 8'h02, 8'h28, 8'h08, 8'h01, 8'h03, 8'h23, 8'h10);
    rollover(8'h99, 8'h12, 8'h31, 8'h20, 8'h01, 8'h01, 8'h00, 8'h40);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
